// ### bench/test_periph_pll_clock_bypass_ctrl.sv
`timescale 1ns/1ps
// Self-checking bench for the peripheral clock bypass control
module test_periph_pll_clock_bypass_ctrl;
    import pcbyp_pkg::*;

    logic                mclk         = 1'b0;
    logic                rstn         = 1'b0;
    logic                psel         = 1'b0;
    logic                penable      = 1'b0;
    logic                pwrite       = 1'b0;
    logic [ADDR_W-1:0]   paddr        = 8'h00;
    logic [DATA_W-1:0]   pwdata       = 32'h00000000;
    logic [DATA_W-1:0]   prdata;
    logic                pready;
    logic                pslverr;
    logic                bootClk      = 1'b0;
    logic [NUM_CLK-1:0]  muxClk       = 8'h00;
    logic [NUM_CLK-1:0]  derivedClk;
    logic [NUM_CLK-1:0]  bypassActive;
    logic [NUM_CLK-1:0]  bypM         = 8'hFF;
    logic [31:0]         seed         = 32'h0000FA52;
    int                  failures     = 0;
    int                  numChecks    = 0;

    pcbyp_ctrl i_dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bootClk(bootClk), .muxClk(muxClk), .derivedClk(derivedClk), .bypassActive(bypassActive));

    // Free-running 25 MHz clock
    always #20 mclk = ~mclk;

    // Xorshift source of stimulus
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Verdict and end of run
    task finish_test;
        if (failures == 0 && numChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    // Compare seen against expected
    task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        numChecks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer, compared with the register model
    task acc(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int                n;
        logic              hit;
        logic [DATA_W-1:0] rd;
        logic              er;
        d = d & 32'h000000FF;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            finish_test();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        hit = (a == OFS_BYPASS) || (a == OFS_SET) || (a == OFS_CLEAR);
        check({31'h0, er}, {31'h0, ~hit});
        if (!wr) begin
            check(rd, hit ? {PAD_ZERO, bypM} : 32'h0);
        end else if (a == OFS_BYPASS) begin
            bypM = d[7:0];
        end else if (a == OFS_SET) begin
            bypM = bypM | d[7:0];
        end else if (a == OFS_CLEAR) begin
            bypM = bypM & ~d[7:0];
        end
    endtask : acc

    // Quiet sources so the switches can settle, then check selection
    task settle;
        @(posedge mclk);
        bootClk <= 1'b0;
        muxClk  <= 8'h00;
        repeat (3) @(posedge mclk);
        #1;
        check({PAD_ZERO, bypassActive}, {PAD_ZERO, bypM});
    endtask : settle

    // Random source levels, output follows the selected source
    task clocks(input int n);
        logic [31:0] r;
        repeat (n) begin
            @(posedge mclk);
            r = rnd();
            bootClk <= r[8];
            muxClk  <= r[7:0];
            @(posedge mclk);
            #1;
            check({PAD_ZERO, derivedClk}, {PAD_ZERO, (bypM & {8{r[8]}}) | (~bypM & r[7:0])});
        end
    endtask : clocks

    // Main sequence
    initial begin
        logic [7:0]  old;
        logic [31:0] r;
        logic [7:0]  tbl [3];
        tbl = '{OFS_BYPASS, OFS_SET, OFS_CLEAR};
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        #1;
        check({PAD_ZERO, bypassActive}, 32'h000000FF);
        acc(1'b0, OFS_BYPASS, 32'h0);
        clocks(6);
        // Each clock moved alone onto the mux path
        for (int k = 0; k < NUM_CLK; k++) begin
            acc(1'b1, OFS_BYPASS, 32'hFF ^ (32'h1 << k));
            settle();
            clocks(4);
        end
        // Random back-to-back traffic over all aliases and unmapped places
        repeat (24) begin
            r = rnd();
            acc(r[8], (r[1:0] == 2'b11) ? r[23:16] : tbl[r[1:0] % 3], rnd());
        end
        settle();
        clocks(8);
        // Source change held off while the boot clock is high
        acc(1'b1, OFS_SET, 32'hFF);
        settle();
        old = bypM;
        @(posedge mclk);
        bootClk <= 1'b1;
        acc(1'b1, OFS_CLEAR, 32'h5A);
        repeat (4) @(posedge mclk);
        #1;
        check({PAD_ZERO, bypassActive}, {PAD_ZERO, old});
        settle();
        acc(1'b0, OFS_SET, 32'h0);
        acc(1'b0, OFS_CLEAR, 32'h0);
        clocks(8);
        finish_test();
    end
endmodule : test_periph_pll_clock_bypass_ctrl

// ### hdl/pcbyp_apb_port.sv
`timescale 1ns/1ps
// APB slave front end: no wait state, registered answer
module pcbyp_apb_port
    import pcbyp_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rstn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [NUM_CLK-1:0] bypassVal,
    output logic [DATA_W-1:0]      prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   wrBase,
    output logic                   wrSet,
    output logic                   wrClear
);
    pcbyp_phase_e phase_r;
    pcbyp_phase_e phase_nxt;
    logic [DATA_W-1:0] prdata_r;
    logic [DATA_W-1:0] prdata_nxt;
    logic              pready_r;
    logic              pslverr_r;
    logic              setup;
    logic              commit;
    logic              hitBase;
    logic              hitSet;
    logic              hitClear;
    logic              mapped;

    // Address decode
    assign hitBase  = (paddr == OFS_BYPASS);
    assign hitSet   = (paddr == OFS_SET);
    assign hitClear = (paddr == OFS_CLEAR);
    assign mapped   = hitBase || hitSet || hitClear;

    // Setup cycle and completing edge
    assign setup  = psel && !penable;
    assign commit = psel && penable && pready_r && (phase_r == PCBYP_ACCESS);
    assign wrBase  = commit && pwrite && hitBase;
    assign wrSet   = commit && pwrite && hitSet;
    assign wrClear = commit && pwrite && hitClear;

    // Every mapped offset reads back the live bypass value
    assign prdata_nxt = (setup && !pwrite && mapped) ? {PAD_ZERO, bypassVal} : '0;
    assign phase_nxt  = setup ? PCBYP_ACCESS : PCBYP_IDLE;

    // Answer registers
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            phase_r   <= PCBYP_IDLE;
            prdata_r  <= '0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            phase_r   <= phase_nxt;
            prdata_r  <= setup ? prdata_nxt : prdata_r;
            pready_r  <= (phase_nxt == PCBYP_ACCESS);
            pslverr_r <= setup && !mapped;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
endmodule : pcbyp_apb_port

// ### hdl/pcbyp_clk_switch.sv
`timescale 1ns/1ps
// Glitch-free two-source switch for one derived clock
module pcbyp_clk_switch
    import pcbyp_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic selBoot,
    input  wire logic bootClk,
    input  wire logic muxClk,
    output logic      clkOut,
    output logic      selActive
);
    logic clkOut_r;
    logic selActive_r;
    logic selActive_nxt;
    logic clkOut_nxt;
    logic bothLow;

    // Change source only while both sources are low
    assign bothLow       = !bootClk && !muxClk;
    assign selActive_nxt = bothLow ? selBoot : selActive_r;
    assign clkOut_nxt    = selActive_nxt ? bootClk : muxClk;

    // Selection and registered clock
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            selActive_r <= 1'b1;
            clkOut_r    <= 1'b0;
        end else begin
            selActive_r <= selActive_nxt;
            clkOut_r    <= clkOut_nxt;
        end
    end

    assign clkOut    = clkOut_r;
    assign selActive = selActive_r;
endmodule : pcbyp_clk_switch

// ### hdl/pcbyp_ctrl.sv
`timescale 1ns/1ps
module pcbyp_ctrl
    import pcbyp_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               rstn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [DATA_W-1:0]  pwdata,
    output logic [DATA_W-1:0]       prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               bootClk,
    input  wire logic [NUM_CLK-1:0] muxClk,
    output logic [NUM_CLK-1:0]      derivedClk,
    output logic [NUM_CLK-1:0]      bypassActive
);
    logic [NUM_CLK-1:0] bypass_r;
    logic [NUM_CLK-1:0] bypass_nxt;
    logic [NUM_CLK-1:0] wrData;
    logic               wrBase;
    logic               wrSet;
    logic               wrClear;

    // Bus front end
    pcbyp_apb_port u_port (
        .mclk      (mclk),
        .rstn      (rstn),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .bypassVal (bypass_r),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .wrBase    (wrBase),
        .wrSet     (wrSet),
        .wrClear   (wrClear)
    );

    // Only the low field bits are stored
    assign wrData = pwdata[NUM_CLK-1:0];

    // Next bypass value from plain, set and clear writes
    assign bypass_nxt = wrBase  ? wrData :
                        wrSet   ? (bypass_r | wrData) :
                        wrClear ? (bypass_r & ~wrData) :
                        bypass_r;

    // Bypass register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bypass_r <= BYPASS_RST;
        end else begin
            bypass_r <= bypass_nxt;
        end
    end

    // One glitch-free switch per derived clock
    genvar k;
    generate
        for (k = 0; k < NUM_CLK; k++) begin : g_sw
            pcbyp_clk_switch u_sw (
                .mclk      (mclk),
                .rstn      (rstn),
                .selBoot   (bypass_r[k]),
                .bootClk   (bootClk),
                .muxClk    (muxClk[k]),
                .clkOut    (derivedClk[k]),
                .selActive (bypassActive[k])
            );
        end
    endgenerate

    // Checks on the register file and the switches
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    logic setupRead;
    logic setupMiss;
    assign setupRead = psel && !penable && !pwrite;
    assign setupMiss = psel && !penable &&
                       (paddr != OFS_BYPASS) && (paddr != OFS_SET) && (paddr != OFS_CLEAR);

    reset_value_a: assert property ($rose(rstn) |-> bypass_r == BYPASS_RST)
        else $error("bypass bits not all one after reset");

    plain_write_a: assert property (wrBase |=> bypass_r == $past(wrData))
        else $error("plain write not stored");

    set_alias_a: assert property (wrSet |=> bypass_r == ($past(bypass_r) | $past(wrData)))
        else $error("set alias wrong result");

    clear_alias_a: assert property (wrClear |=> bypass_r == ($past(bypass_r) & ~$past(wrData)))
        else $error("clear alias wrong result");

    hold_value_a: assert property (!(wrBase || wrSet || wrClear) |=> $stable(bypass_r))
        else $error("bypass changed without write");

    set_readback_a: assert property (setupRead && paddr == OFS_SET
                                     |=> prdata == {PAD_ZERO, $past(bypass_r)})
        else $error("set alias readback mismatch");

    ready_wait_a: assert property (psel && !penable |=> pready ##1 !pready || (psel && !penable))
        else $error("ready not one cycle after setup");

    miss_error_a: assert property (setupMiss |=> pslverr && prdata == '0)
        else $error("unmapped access not flagged");

    main_num_a: assert property (bypassActive[BYP_MAIN_NUM]
                                 |-> derivedClk[BYP_MAIN_NUM] == $past(bootClk))
        else $error("numerator update clock not on boot");

    peri_den_a: assert property (bypassActive[BYP_PERI_DEN]
                                 |-> derivedClk[BYP_PERI_DEN] == $past(bootClk))
        else $error("denominator update clock not on boot");

    fabric_user_a: assert property (bypassActive[BYP_FABRIC_USER]
                                    |-> derivedClk[BYP_FABRIC_USER] == $past(bootClk))
        else $error("fabric user clock not on boot");

    card_host_a: assert property (bypassActive[BYP_CARD_HOST]
                                  |-> derivedClk[BYP_CARD_HOST] == $past(bootClk))
        else $error("card host clock not on boot");

    debounce_clk_a: assert property (bypassActive[BYP_DEBOUNCE]
                                     |-> derivedClk[BYP_DEBOUNCE] == $past(bootClk))
        else $error("debounce clock not on boot");

    timestamp_clk_a: assert property (bypassActive[BYP_TIMESTAMP]
                                      |-> derivedClk[BYP_TIMESTAMP] == $past(bootClk))
        else $error("timestamp clock not on boot");

    net_free_a: assert property (
        (bypassActive[BYP_NET_FREE_A] |-> derivedClk[BYP_NET_FREE_A] == $past(bootClk)) and
        (bypassActive[BYP_NET_FREE_B] |-> derivedClk[BYP_NET_FREE_B] == $past(bootClk)))
        else $error("network free clock not on boot");

    generate
        for (k = 0; k < NUM_CLK; k++) begin : g_chk
            mux_route_a: assert property (!bypassActive[k]
                                          |-> derivedClk[k] == $past(muxClk[k]))
                else $error("derived clock not from mux");

            no_glitch_a: assert property ($changed(bypassActive[k]) |-> !derivedClk[k])
                else $error("source switched while clock high");

            sel_follow_a: assert property (bypassActive[k] != bypass_r[k] && !bootClk && !muxClk[k]
                                           |=> bypassActive[k] == $past(bypass_r[k]))
                else $error("switch ignored safe point");
        end
    endgenerate

    set_write_c: cover property (wrSet ##1 bypass_r != $past(bypass_r));
    clear_write_c: cover property (wrClear ##1 bypass_r == '0);
    to_mux_c: cover property ($fell(bypassActive[BYP_DEBOUNCE]));
    back_boot_c: cover property ($rose(bypassActive[BYP_MAIN_NUM]));
    miss_err_c: cover property (pslverr && pready);
endmodule : pcbyp_ctrl

// ### include/pcbyp_pkg.sv
// Shared constants for the peripheral clock bypass control
package pcbyp_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_BYPASS = 8'h14;
    localparam logic [7:0] OFS_SET    = 8'h18;
    localparam logic [7:0] OFS_CLEAR  = 8'h1C;

    // Widths
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int NUM_CLK = 8;
    localparam int PAD_W   = DATA_W - NUM_CLK;

    // Reset value: every clock starts on the boot clock
    localparam logic [NUM_CLK-1:0] BYPASS_RST = 8'hFF;
    localparam logic [PAD_W-1:0]   PAD_ZERO   = 24'h000000;

    // Bit positions of the bypass fields
    localparam int BYP_MAIN_NUM    = 7;
    localparam int BYP_PERI_DEN    = 6;
    localparam int BYP_FABRIC_USER = 5;
    localparam int BYP_CARD_HOST   = 4;
    localparam int BYP_DEBOUNCE    = 3;
    localparam int BYP_TIMESTAMP   = 2;
    localparam int BYP_NET_FREE_B  = 1;
    localparam int BYP_NET_FREE_A  = 0;

    // Bus phase encoding for the slave
    typedef enum logic [1:0] {
        PCBYP_IDLE   = 2'b01,
        PCBYP_ACCESS = 2'b10
    } pcbyp_phase_e;
endpackage : pcbyp_pkg
